// ==== logic/asd_pkg.sv ====
// Shared constants, types and helpers of the converter output stage
`default_nettype none

package asd_pkg;

   // Word widths
   localparam int DATA_W   = 14;   // Converted word width
   localparam int DITHER_W = 8;    // Width of the dither code
   localparam int LFSR_W   = 15;   // Pseudo-random generator length
   localparam int ADDR_W   = 4;    // Register port address width
   localparam int REG_W    = 16;   // Register port data width
   localparam int CFG_W    = 4;    // Control bits that cross to the link

   // Generator: x^15 + x^14 + 1, maximal length, never all zero
   localparam logic [LFSR_W-1:0] LFSR_SEED   = 15'h0001;
   localparam int                LFSR_TAP_HI = 14;
   localparam int                LFSR_TAP_LO = 13;

   // Register offsets (byte addresses)
   localparam logic [ADDR_W-1:0] CTRL_ADDR   = 4'h0;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h4;

   // Control register layout and reset value
   localparam int              CTRL_SCRAMBLE_BIT = 0;
   localparam int              CTRL_DITHER_BIT   = 1;
   localparam int              CTRL_MODE_LSB     = 2;
   localparam logic [CFG_W-1:0] CTRL_RESET       = 4'h0;

   // Status register layout
   localparam int STATUS_STICKY_BIT = 0;
   localparam int STATUS_LIVE_BIT   = 1;

   // Zero constants at the widths they meet
   localparam logic [REG_W-1:0]    REG_ZERO  = 16'h0000;
   localparam logic [DATA_W-1:0]   DATA_ZERO = 14'h0000;
   localparam logic [DITHER_W-1:0] DITH_ZERO = 8'h00;
   localparam logic [DATA_W-DITHER_W-1:0] DITH_PAD = 6'h00;

   // Four-level output format setting
   typedef enum logic [1:0] {
      ASD_MODE_OB_PLAIN = 2'h0,    // Offset binary
      ASD_MODE_OB_STAB  = 2'h1,    // Offset binary
      ASD_MODE_TC_STAB  = 2'h2,    // Two's complement
      ASD_MODE_TC_PLAIN = 2'h3     // Two's complement
   } asd_mode_t;

   // True for the two upper levels of the format setting
   function automatic logic asd_is_twos(input asd_mode_t m);
      return (m == ASD_MODE_TC_STAB) || (m == ASD_MODE_TC_PLAIN);
   endfunction

   // Fold the low bit into every upper bit; the low bit itself is kept
   function automatic logic [DATA_W-1:0] asd_scramble(
      input logic [DATA_W-1:0] w);
      return {w[DATA_W-1:1] ^ {(DATA_W-1){w[0]}}, w[0]};
   endfunction

endpackage

`default_nettype wire

// ==== logic/asd_lfsr.sv ====
// Maximal-length pseudo-random generator, one step per sample
`default_nettype none

module asd_lfsr (
   // Clock and reset of the sample domain
   input  wire logic                      clk,
   input  wire logic                      rst,
   // Generator state
   output logic [asd_pkg::LFSR_W-1:0]     state
);

   logic [asd_pkg::LFSR_W-1:0] state_r;    // Shift register
   logic [asd_pkg::LFSR_W-1:0] state_nxt;  // Value after one step
   logic                       feedback;   // XOR of the two taps

   // Taps give the longest sequence, so the seed never recurs early
   assign feedback  = state_r[asd_pkg::LFSR_TAP_HI]
                    ^ state_r[asd_pkg::LFSR_TAP_LO];
   assign state_nxt = {state_r[asd_pkg::LFSR_W-2:0], feedback};
   assign state     = state_r;

   // Advance once per sample edge; the seed keeps it off all-zero
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= asd_pkg::LFSR_SEED;
      end else begin
         state_r <= state_nxt;
      end
   end

endmodule // asd_lfsr

`default_nettype wire

// ==== logic/asd_fwd_clock.sv ====
// Forwarded output clock pair built from both sample strobe edges
`default_nettype none

module asd_fwd_clock (
   // Sample strobe and its reset
   input  wire logic  sample_strobe,
   input  wire logic  rst,
   // Output clock pair
   output logic       clk_true,
   output logic       clk_comp
);

   logic rise_tgl_r;   // Toggles on every rising strobe edge
   logic fall_tgl_r;   // Copies the rise toggle on each falling edge

   // Rising edge: flips the pair at the moment new data is launched
   always_ff @(posedge sample_strobe) begin
      if (rst) begin
         rise_tgl_r <= 1'h0;
      end else begin
         rise_tgl_r <= ~rise_tgl_r;
      end
   end

   // Falling edge: brings the pair back, half a sample later
   always_ff @(negedge sample_strobe) begin
      if (rst) begin
         fall_tgl_r <= 1'h0;
      end else begin
         fall_tgl_r <= rise_tgl_r;
      end
   end

   // Only one toggle moves at a time, so the XOR cannot glitch
   assign clk_comp = rise_tgl_r ^ fall_tgl_r;
   assign clk_true = ~clk_comp;

endmodule // asd_fwd_clock

`default_nettype wire

// ==== logic/asd_output_stage.sv ====
// Output stage of the 14-bit converter: format, dither, scramble, clock
//
// Contract
// - Drive delayed strobe copy as true/complement pair
// - New word: true clock falls, complement rises
// - Scramble XORs low bit into upper bits
// - Low bit, overflow, clocks untouched by scrambling
// - Scramble only while enable high
// - Output word is 14 bits plus overflow
// - Optional dither from long pseudo-random generator
// - Subtract injected dither value from same sample
// - Overflow output high when over or under range
// - Four-level format: offset binary or two's complement
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`default_nettype none

module asd_output_stage (
   // Core clock and reset
   input  wire logic                           core_clk,
   input  wire logic                           srst,
   // Register port
   input  wire logic [asd_pkg::ADDR_W-1:0]     reg_addr,
   input  wire logic [asd_pkg::REG_W-1:0]      reg_wdata,
   input  wire logic                           reg_wr,
   input  wire logic                           reg_rd,
   output logic      [asd_pkg::REG_W-1:0]      reg_rdata,
   // Link side: strobe and raw result from the converter core
   input  wire logic                           sample_strobe,
   input  wire logic [asd_pkg::DATA_W-1:0]     raw_word,
   input  wire logic                           raw_over,
   input  wire logic                           raw_under,
   // Dither code to the injection path
   output logic      [asd_pkg::DITHER_W-1:0]   dither_code,
   // Parallel outputs
   output logic      [asd_pkg::DATA_W-1:0]     data_out,
   output logic                                range_overflow,
   output logic                                fwd_clock_true,
   output logic                                fwd_clock_comp
);

   // Core domain: register port

   logic [asd_pkg::CFG_W-1:0] ctrl_r;        // Control bits
   logic [asd_pkg::CFG_W-1:0] ctrl_nxt;      // Next control bits
   logic                      sticky_r;      // Overflow seen since clear
   logic                      sticky_nxt;    // Next sticky flag
   logic                      ovf_meta_r;    // Overflow sync, stage one
   logic                      ovf_sync_r;    // Overflow sync, stage two
   logic [asd_pkg::REG_W-1:0] rdata_r;       // Read data register
   logic [asd_pkg::REG_W-1:0] rdata_nxt;     // Read data for next cycle
   logic                      hit_ctrl;      // Address hits control
   logic                      hit_status;    // Address hits status
   logic                      clr_sticky;    // Write one to sticky bit
   logic [asd_pkg::REG_W-1:0] ctrl_view;     // Control, padded to bus
   logic [asd_pkg::REG_W-1:0] status_view;   // Status, padded to bus

   // Address decode
   assign hit_ctrl   = (reg_addr == asd_pkg::CTRL_ADDR);
   assign hit_status = (reg_addr == asd_pkg::STATUS_ADDR);

   // Control takes the low four bits of the write; other writes leave it alone
   assign ctrl_nxt = (reg_wr && hit_ctrl)
                   ? reg_wdata[asd_pkg::CFG_W-1:0] : ctrl_r;

   // A write of one clears the sticky flag, but a new overflow wins
   assign clr_sticky = reg_wr && hit_status
                     && reg_wdata[asd_pkg::STATUS_STICKY_BIT];
   assign sticky_nxt = ovf_sync_r || (sticky_r && !clr_sticky);

   // Register views; unused upper bits read as zero
   assign ctrl_view = {{(asd_pkg::REG_W-asd_pkg::CFG_W){1'h0}}, ctrl_r};
   assign status_view = {{(asd_pkg::REG_W-2){1'h0}}, ovf_sync_r,
                         sticky_r};

   // Read mux; unmapped addresses and idle cycles return zero
   assign rdata_nxt = !reg_rd    ? asd_pkg::REG_ZERO
                    : hit_ctrl   ? ctrl_view
                    : hit_status ? status_view
                    : asd_pkg::REG_ZERO;

   // Control, sticky flag and read data
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctrl_r   <= asd_pkg::CTRL_RESET;
         sticky_r <= 1'h0;
         rdata_r  <= asd_pkg::REG_ZERO;
      end else begin
         ctrl_r   <= ctrl_nxt;
         sticky_r <= sticky_nxt;
         rdata_r  <= rdata_nxt;
      end
   end

   // Overflow level into the core domain; excursions shorter than
   // about one core cycle may be missed, the flag is only a monitor
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ovf_meta_r <= 1'h0;
         ovf_sync_r <= 1'h0;
      end else begin
         ovf_meta_r <= range_overflow;
         ovf_sync_r <= ovf_meta_r;
      end
   end

   assign reg_rdata = rdata_r;

   // Link domain: runs on the sample strobe

   logic                          lrst_meta_r;  // Reset sync, stage one
   logic                          lrst;         // Reset in link domain
   logic [asd_pkg::CFG_W-1:0]     cfg_meta_r;   // Control sync, stage one
   logic [asd_pkg::CFG_W-1:0]     cfg_r;        // Control in link domain
   logic                          scramble_enable; // Scrambling in effect
   logic                          dither_enable;   // Dither mode on
   asd_pkg::asd_mode_t            fmt_mode;     // Format setting
   logic                          fmt_twos;     // Two's complement out
   logic [asd_pkg::LFSR_W-1:0]    lfsr_state;   // Generator state
   logic [asd_pkg::DATA_W-1:0]    dith_wide;    // Dither at word width
   logic [asd_pkg::DATA_W-1:0]    undithered;   // Raw minus dither
   logic [asd_pkg::DATA_W-1:0]    fmt_word;     // Formatted result
   logic [asd_pkg::DATA_W-1:0]    out_nxt;      // Word to launch
   logic                          ovf_nxt;      // Range flag to launch
   logic [asd_pkg::DATA_W-1:0]    data_r;       // Launched word
   logic                          ovf_r;        // Launched range flag
   logic [asd_pkg::DATA_W-1:0]    fmt_sign;     // Sign flip mask

   // Core reset and control enter the link domain through two flops;
   // control is quasi-static, so a bit-wise sync is enough
   always_ff @(posedge sample_strobe) begin
      lrst_meta_r <= srst;
      lrst        <= lrst_meta_r;
      cfg_meta_r  <= ctrl_r;
      cfg_r       <= cfg_meta_r;
   end

   // Field extraction of the synchronised control
   assign scramble_enable = cfg_r[asd_pkg::CTRL_SCRAMBLE_BIT];
   assign dither_enable   = cfg_r[asd_pkg::CTRL_DITHER_BIT];
   assign fmt_mode = asd_pkg::asd_mode_t'(
                     cfg_r[asd_pkg::CTRL_MODE_LSB +: 2]);
   assign fmt_twos = asd_pkg::asd_is_twos(fmt_mode);

   // Generator steps on every sample edge
   asd_lfsr u_lfsr (
      .clk   (sample_strobe),
      .rst   (lrst),
      .state (lfsr_state)
   );

   // Dither code to the injection path; zero when dither is off
   assign dither_code = dither_enable
                      ? lfsr_state[asd_pkg::DITHER_W-1:0]
                      : asd_pkg::DITH_ZERO;

   // The same code is taken back out of the result of this sample
   assign dith_wide  = {asd_pkg::DITH_PAD, dither_code};
   assign undithered = raw_word - dith_wide;

   // Two's complement is offset binary with the top bit inverted
   assign fmt_sign = {fmt_twos, {(asd_pkg::DATA_W-1){1'h0}}};
   assign fmt_word = undithered ^ fmt_sign;

   // Scrambling is the last step, on the finished word
   assign out_nxt = scramble_enable
                  ? asd_pkg::asd_scramble(fmt_word)
                  : fmt_word;
   assign ovf_nxt = raw_over || raw_under;

   // Launch register; new data leaves on the rising strobe edge
   always_ff @(posedge sample_strobe) begin
      if (lrst) begin
         data_r <= asd_pkg::DATA_ZERO;
         ovf_r  <= 1'h0;
      end else begin
         data_r <= out_nxt;
         ovf_r  <= ovf_nxt;
      end
   end

   assign data_out       = data_r;
   assign range_overflow = ovf_r;

   // Output clock pair; falls with each launch, rises half a cycle on
   asd_fwd_clock u_fwd_clock (
      .sample_strobe (sample_strobe),
      .rst           (lrst),
      .clk_true      (fwd_clock_true),
      .clk_comp      (fwd_clock_comp)
   );

   // Checks

   logic                       lrst_d_r;    // Link reset, one edge later
   logic                       chk_off;     // Checks at rest
   logic [asd_pkg::DATA_W-1:0] scr_word;    // Scrambled form of result
   logic                       fmt_lsb;     // Low bit of result
   logic [asd_pkg::LFSR_W-1:0] lfsr_expect; // Generator after one step
   logic                       diff_msb;    // Top bit before format

   assign scr_word    = asd_pkg::asd_scramble(fmt_word);
   assign fmt_lsb     = fmt_word[0];
   assign diff_msb    = undithered[asd_pkg::DATA_W-1];
   assign lfsr_expect = {lfsr_state[asd_pkg::LFSR_W-2:0],
                         lfsr_state[asd_pkg::LFSR_TAP_HI]
                         ^ lfsr_state[asd_pkg::LFSR_TAP_LO]};

   // Link reset seen one edge late: the first edge after release still
   // holds the old reset in every flop, so no step is judged there
   always_ff @(posedge sample_strobe) begin
      lrst_d_r <= lrst;
   end

   // Core reset is known from time zero, while the link flops start
   // unknown until the strobe has carried the reset across
   assign chk_off = srst || lrst || lrst_d_r;

   // Launch of a scrambled word, one edge after its inputs
   sequence s_scr_launch;
      ##1 (data_out == $past(scr_word));
   endsequence

   // Launch of an unmodified word
   sequence s_plain_launch;
      ##1 (data_out == $past(fmt_word));
   endsequence

   // One generator step
   sequence s_lfsr_step;
      ##1 (lfsr_state == $past(lfsr_expect));
   endsequence

   // Scrambled words carry the folded result
   a_scramble_word: assert property (
      @(posedge sample_strobe) disable iff (chk_off)
      scramble_enable |-> s_scr_launch)
      else $error("scrambled word does not match the result");

   // Without scrambling the result goes out as it is
   a_plain_word: assert property (
      @(posedge sample_strobe) disable iff (chk_off)
      !scramble_enable |-> s_plain_launch)
      else $error("word changed while scrambling is off");

   // Low bit is never touched
   a_lsb_kept: assert property (
      @(posedge sample_strobe) disable iff (chk_off)
      1'h1 |=> (data_out[0] == $past(fmt_lsb)))
      else $error("low data bit altered");

   // Range flag follows the converter one edge later
   a_range_flag: assert property (
      @(posedge sample_strobe) disable iff (chk_off)
      1'h1 |=> (range_overflow == ($past(raw_over) || $past(raw_under))))
      else $error("range overflow flag wrong");

   // Dither off: code is zero and result passes untouched
   a_dither_off: assert property (
      @(posedge sample_strobe) disable iff (chk_off)
      !dither_enable |-> (dither_code == asd_pkg::DITH_ZERO
                          && undithered == raw_word))
      else $error("dither active while disabled");

   // Dither on, offset binary, no scrambling: the injected code is subtracted from the same sample
   a_dither_cancel: assert property (
      @(posedge sample_strobe) disable iff (chk_off)
      (dither_enable && !scramble_enable && !fmt_twos)
      |=> (data_out + $past(dither_code) == $past(raw_word)))
      else $error("dither code not removed from result");

   // Dither with scrambling: undo fold and format, add the code back
   a_dither_scr: assert property (
      @(posedge sample_strobe) disable iff (chk_off)
      (dither_enable && scramble_enable)
      |=> (((asd_pkg::asd_scramble(data_out) ^ $past(fmt_sign))
            + $past(dither_code)) == $past(raw_word)))
      else $error("scrambled word not built from the final result");

   // Upper levels invert the top bit before scrambling
   a_twos_msb: assert property (
      @(posedge sample_strobe) disable iff (chk_off)
      (fmt_twos && !scramble_enable)
      |=> (data_out[asd_pkg::DATA_W-1] != $past(diff_msb)))
      else $error("two's complement top bit wrong");

   // Generator takes its step each sample while it is not all zero
   a_lfsr_step: assert property (
      @(posedge sample_strobe) disable iff (chk_off)
      (lfsr_state != {asd_pkg::LFSR_W{1'h0}}) |-> s_lfsr_step)
      else $error("generator did not take its step");

   // Just before each launch the pair is back: true high, complement low
   a_clock_pair: assert property (
      @(posedge sample_strobe) disable iff (chk_off)
      fwd_clock_true && !fwd_clock_comp)
      else $error("output clock pair not back before launch");

   // Half a cycle after a launch the true clock is low, then high again
   a_clock_launch: assert property (
      @(negedge sample_strobe) disable iff (chk_off)
      !fwd_clock_true && fwd_clock_comp)
      else $error("output clock not low after launch");

endmodule // asd_output_stage

`default_nettype wire

// ==== verification/asd_rx_model.sv ====
// Receiver model: captures words on the forwarded clock and descrambles
`default_nettype none

module asd_rx_model (
   // Capture clock and incoming word
   input  wire logic                          cap_clk,
   input  wire logic [asd_pkg::DATA_W-1:0]    word_in,
   input  wire logic                          ovf_in,
   // Receiver knows whether the sender scrambles
   input  wire logic                          descramble,
   // Recovered word
   output logic      [asd_pkg::DATA_W-1:0]    word_rx,
   output logic                               ovf_rx
);
   timeunit 1ns;
   timeprecision 1ps;

   // Capture on the rising true clock; the low bit undoes the fold
   always_ff @(posedge cap_clk) begin
      word_rx <= descramble ?
                 {word_in[13:1] ^ {13{word_in[0]}}, word_in[0]} :
                 word_in;
      ovf_rx  <= ovf_in;
   end

endmodule // asd_rx_model

`default_nettype wire

// ==== verification/asd_output_stage_tb.sv ====
// Self-checking bench of the converter output stage
`default_nettype none

module asd_output_stage_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // Core side
   logic                         core_clk, srst, reg_wr, reg_rd;
   logic [asd_pkg::ADDR_W-1:0]   reg_addr;
   logic [asd_pkg::REG_W-1:0]    reg_wdata, reg_rdata;
   // Link side
   logic                         sample_strobe, raw_over, raw_under;
   logic                         range_overflow, ovf_rx;
   logic                         fwd_clock_true, fwd_clock_comp;
   logic [asd_pkg::DATA_W-1:0]   raw_word, data_out, word_rx;
   logic [asd_pkg::DITHER_W-1:0] dither_code, last_d;
   // Settings the expectations follow
   logic                         scr;
   logic [1:0]                   mode;
   int                           n_errors = 0;
   int                           samples_checked = 0;

   asd_output_stage dut (
      .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .sample_strobe(sample_strobe),
      .raw_word(raw_word), .raw_over(raw_over), .raw_under(raw_under),
      .dither_code(dither_code), .data_out(data_out),
      .range_overflow(range_overflow), .fwd_clock_true(fwd_clock_true),
      .fwd_clock_comp(fwd_clock_comp));

   asd_rx_model rx (
      .cap_clk(fwd_clock_true), .word_in(data_out),
      .ovf_in(range_overflow), .descramble(scr),
      .word_rx(word_rx), .ovf_rx(ovf_rx));

   // Core clock 100 ns; strobe 48 ns with an unrelated phase
   initial begin
      core_clk = 1'h0;
      forever #50 core_clk = ~core_clk;
   end
   initial begin
      sample_strobe = 1'h0;
      #13;
      forever #24 sample_strobe = ~sample_strobe;
   end

   // Count one comparison, report a mismatch at once
   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (!ok) begin
         n_errors++;
         $display("unexpected %0t %s", $time, m);
      end
   endtask

   // One-cycle register write
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'h0;
   endtask

   // One-cycle read; data judged in the following cycle only
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge core_clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      #1 chk(reg_rdata === e, "read data");
   endtask

   // Program control and let it cross to the link
   task automatic cfg(input logic s, input logic d, input logic [1:0] m);
      wr(asd_pkg::CTRL_ADDR, {12'h000, m, d, s});
      scr = s;
      mode = m;
      repeat (6) @(posedge sample_strobe);
   endtask

   // Send one sample and judge the word, the clock pair and the capture
   task automatic xfer(input logic [13:0] v, input logic ov, input logic un);
      logic [13:0] e;
      @(posedge sample_strobe);
      raw_word <= v;
      raw_over <= ov;
      raw_under <= un;
      @(negedge sample_strobe);
      last_d = dither_code;
      @(posedge sample_strobe);
      #1;
      e = v - {asd_pkg::DITH_PAD, last_d};
      if (mode[1]) begin
         e[13] = ~e[13];
      end
      chk(fwd_clock_true === 1'h0 && fwd_clock_comp === 1'h1, "clk");
      chk(data_out === (scr ? {e[13:1] ^ {13{e[0]}}, e[0]} : e),
          "word");
      chk(range_overflow === (ov | un), "overflow");
      @(negedge sample_strobe);
      #1;
      chk(fwd_clock_true === 1'h1 && fwd_clock_comp === 1'h0, "clk");
      chk(word_rx === e && ovf_rx === (ov | un), "capture");
   endtask

   // Reset levels, register reset values, reserved bits and addresses
   task automatic t_reset();
      chk(data_out === 14'h0000 && range_overflow === 1'h0, "rst out");
      chk(fwd_clock_true === 1'h1 && fwd_clock_comp === 1'h0, "rst");
      srst <= 1'h0;
      rd(asd_pkg::CTRL_ADDR, 16'h0000);
      rd(asd_pkg::STATUS_ADDR, 16'h0000);
      wr(asd_pkg::CTRL_ADDR, 16'hFFF5);
      rd(asd_pkg::CTRL_ADDR, 16'h0005);
      wr(4'hC, 16'hFFFF);
      rd(4'h8, 16'h0000);
      rd(asd_pkg::CTRL_ADDR, 16'h0005);
      $display("test reset done");
   endtask

   // Every format level, plain and scrambled, samples on every second rising strobe edge
   task automatic t_format();
      for (int m = 0; m < 4; m++) begin
         cfg(1'h0, 1'h0, m[1:0]);
         xfer(14'h0000, 1'h0, 1'h0);
         xfer(14'h3FFF, 1'h0, 1'h0);
         cfg(1'h1, 1'h0, m[1:0]);
         xfer(14'h1235, 1'h0, 1'h0);
         xfer(14'h2AAA, 1'h0, 1'h0);
      end
      $display("test format done");
   endtask

   // Dither: code moves, is removed, and rests at zero when off
   task automatic t_dither();
      logic [7:0] first;
      logic       moved;
      moved = 1'h0;
      cfg(1'h0, 1'h1, 2'h0);
      xfer(14'h0100, 1'h0, 1'h0);
      first = last_d;
      for (int i = 0; i < 4; i++) begin
         xfer(14'h0004, 1'h0, 1'h0);
         moved = moved | (last_d !== first);
      end
      chk(moved === 1'h1, "dither stuck");
      cfg(1'h1, 1'h1, 2'h3);
      xfer(14'h2001, 1'h0, 1'h0);
      cfg(1'h0, 1'h0, 2'h0);
      chk(dither_code === 8'h00, "dither off");
      $display("test dither done");
   endtask

   // Over and under range, live and sticky status, clear by write
   task automatic t_overflow();
      xfer(14'h3FFF, 1'h1, 1'h0);
      repeat (5) @(posedge core_clk);
      rd(asd_pkg::STATUS_ADDR, 16'h0003);
      xfer(14'h0000, 1'h0, 1'h1);
      xfer(14'h0800, 1'h0, 1'h0);
      repeat (5) @(posedge core_clk);
      rd(asd_pkg::STATUS_ADDR, 16'h0001);
      wr(asd_pkg::STATUS_ADDR, 16'h0001);
      rd(asd_pkg::STATUS_ADDR, 16'h0000);
      $display("test overflow done");
   endtask

   // Counts, verdict and end of run
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Bound on the whole run
   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      conclude();
   end

   // Main sequence
   initial begin
      srst = 1'h1;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      raw_word = 14'h0000;
      raw_over = 1'h0;
      raw_under = 1'h0;
      scr = 1'h0;
      mode = 2'h0;
      last_d = 8'h00;
      repeat (5) @(posedge core_clk);
      t_reset();
      t_format();
      t_dither();
      t_overflow();
      conclude();
   end

endmodule // asd_output_stage_tb

`default_nettype wire
